// *** fssp_host.sv ***
// Host controller driving an asynchronous parallel flash through its pins.
// Assumes the user holds a request until ready; flash pins are asynchronous.
//
// Contract
// - Host sends identification exit after seeing failure bit.
// - Lock half B with four cycles, bit 1 zero in last.
// - Host sends identification exit after register or lock query.
// - Query mode by 98h at 55h; left only by identification exit.
// - Identification exit as three cycles or single F0 write.
`default_nettype none
module fssp_host #(
   parameter int unsigned POLL_LIMIT = 100000
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               arst_n,
   // User request and response
   input  wire fssp_pkg::fssp_req_t req,
   input  wire logic               req_valid,
   output logic                    req_ready,
   output fssp_pkg::fssp_rsp_t     rsp,
   // Flash pins
   output logic [19:0]             fl_addr,
   input  wire logic [15:0]        fl_dq_i,
   output logic [15:0]             fl_dq_o,
   output logic                    fl_dq_oe,
   output logic                    fl_ce_n,
   output logic                    fl_oe_n,
   output logic                    fl_we_n,
   input  wire logic               fl_rdy_i
);
   // Poll counter is 24 bits wide
   if (POLL_LIMIT < 2 || POLL_LIMIT > 32'h00FF_FFFF) begin : g_bad_limit
      $error("POLL_LIMIT out of range");
   end

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_PULSE = 3'b010,
      ST_HOLD  = 3'b011,
      ST_NEXT  = 3'b100,
      ST_WAIT  = 3'b101,
      ST_DONE  = 3'b110
   } fssp_st_t;

   // Synchronisers for the data and ready inputs
   logic [16:0] s1_q, s2_q, s3_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 17'h0_0000;
         s2_q <= 17'h0_0000;
         s3_q <= 17'h0_0000;
      end else begin
         s1_q <= {fl_rdy_i, fl_dq_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // Stable when last two stages agree
   wire        in_stable = (s2_q == s3_q);
   wire [15:0] rd_data   = s3_q[15:0];
   wire        rdy_pin   = s3_q[16];

   fssp_st_t            st_q, st_d;
   fssp_pkg::fssp_req_t cur_q, cur_d;
   logic [2:0]          cyc_q, cyc_d;
   logic [3:0]          tmr_q, tmr_d;
   logic [23:0]         wt_q, wt_d;
   logic                rd_q, rd_d;
   logic                alt_q, alt_d;
   logic                first_q, first_d;
   fssp_pkg::fssp_rsp_t rsp_q, rsp_d;

   // Bus cycle address and data for cycle index
   logic [19:0] c_addr;
   logic [15:0] c_data;
   logic        c_read;
   logic [2:0]  n_cycles;
   logic        poll_after;
   always_comb begin
      c_addr     = {8'h00, fssp_pkg::ADDR_UNLK1};
      c_data     = {8'h00, fssp_pkg::CODE_UNLK1};
      c_read     = 1'b0;
      n_cycles   = 3'd3;
      poll_after = 1'b0;
      if (cyc_q == 3'd1 || cyc_q == 3'd4) begin
         c_addr = {8'h00, fssp_pkg::ADDR_UNLK2};
         c_data = {8'h00, fssp_pkg::CODE_UNLK2};
      end else if (cyc_q == 3'd2) begin
         c_data = {8'h00, fssp_pkg::CODE_PROGRAM};
      end
      case (cur_q.op)
         fssp_pkg::OP_READ: begin
            n_cycles = 3'd1;
            c_read   = 1'b1;
            c_addr   = cur_q.addr;
         end
         // Shared suspend and resume codes, any address
         // shared codes
         fssp_pkg::OP_SUSPEND, fssp_pkg::OP_RESUME, fssp_pkg::OP_QUERY: begin
            n_cycles = 3'd1;
            c_addr   = cur_q.addr;
            c_data   = {8'h00, (cur_q.op == fssp_pkg::OP_SUSPEND) ? fssp_pkg::CODE_SUSPEND
                       : (cur_q.op == fssp_pkg::OP_RESUME) ? fssp_pkg::CODE_RESUME
                       : fssp_pkg::CODE_QUERY};
            if (cur_q.op == fssp_pkg::OP_QUERY) c_addr = {8'h00, fssp_pkg::ADDR_QUERY};
         end
         fssp_pkg::OP_ID_EXIT, fssp_pkg::OP_ID_ENTRY: begin
            if (cyc_q == 3'd2) c_data = {8'h00, (cur_q.op == fssp_pkg::OP_ID_EXIT)
                                        ? fssp_pkg::CODE_ID_EXIT : fssp_pkg::CODE_ID_ENTRY};
         end
         fssp_pkg::OP_PROGRAM, fssp_pkg::OP_SEC_PGM, fssp_pkg::OP_LOCK_B,
         fssp_pkg::OP_SET_CFG, fssp_pkg::OP_BLKB_STAT, fssp_pkg::OP_LOCK_RPT: begin
            n_cycles   = 3'd4;
            poll_after = (cur_q.op == fssp_pkg::OP_PROGRAM || cur_q.op == fssp_pkg::OP_SEC_PGM);
            if (cyc_q == 3'd2) begin
               case (cur_q.op)
                  fssp_pkg::OP_SEC_PGM, fssp_pkg::OP_LOCK_B:
                     c_data = {8'h00, fssp_pkg::CODE_SEC_REG};
                  fssp_pkg::OP_SET_CFG: c_data = {8'h00, fssp_pkg::CODE_SET_CFG};
                  fssp_pkg::OP_BLKB_STAT, fssp_pkg::OP_LOCK_RPT:
                     c_data = {8'h00, fssp_pkg::CODE_ID_ENTRY};
                  default: c_data = {8'h00, fssp_pkg::CODE_PROGRAM};
               endcase
            end else if (cyc_q == 3'd3) begin
               c_addr = cur_q.addr;
               c_data = cur_q.data;
               // lock half B, bit 1 zero
               if (cur_q.op == fssp_pkg::OP_LOCK_B) begin
                  c_addr = {8'h00, fssp_pkg::ADDR_LOCK_B};
                  c_data = {8'h00, fssp_pkg::CODE_LOCK_B};
               end
               if (cur_q.op == fssp_pkg::OP_BLKB_STAT) begin
                  c_addr = {8'h00, fssp_pkg::ADDR_LOCK_B};
                  c_read = 1'b1;
               end
               if (cur_q.op == fssp_pkg::OP_LOCK_RPT) begin
                  c_addr = {cur_q.addr[19:12], fssp_pkg::ADDR_LOCK_RPT};
                  c_read = 1'b1;
               end
            end
         end
         fssp_pkg::OP_SECT_ERS, fssp_pkg::OP_CHIP_ERS, fssp_pkg::OP_LOCKDOWN: begin
            n_cycles   = 3'd6;
            poll_after = (cur_q.op != fssp_pkg::OP_LOCKDOWN);
            if (cyc_q == 3'd2) c_data = {8'h00, fssp_pkg::CODE_SETUP};
            if (cyc_q == 3'd3) c_data = {8'h00, fssp_pkg::CODE_UNLK1};
            if (cyc_q == 3'd5) begin
               c_addr = (cur_q.op == fssp_pkg::OP_CHIP_ERS) ? {8'h00, fssp_pkg::ADDR_UNLK1}
                        : cur_q.addr;
               c_data = {8'h00, (cur_q.op == fssp_pkg::OP_CHIP_ERS) ? fssp_pkg::CODE_CHIP_ERS
                        : (cur_q.op == fssp_pkg::OP_SECT_ERS) ? fssp_pkg::CODE_SECT_ERS
                        : fssp_pkg::CODE_LOCKDOWN};
            end
         end
         default: n_cycles = 3'd1;
      endcase
   end

   // Sequencer: setup, strobe pulse, hold, then poll after program or erase
   always_comb begin
      st_d    = st_q;
      cur_d   = cur_q;
      cyc_d   = cyc_q;
      tmr_d   = tmr_q;
      wt_d    = wt_q;
      rd_d    = rd_q;
      alt_d   = alt_q;
      first_d = first_q;
      rsp_d   = rsp_q;
      rsp_d.done = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (req_valid) begin
               cur_d = req;
               cyc_d = 3'd0;
               tmr_d = 4'd0;
               rd_d  = 1'b0;
               st_d  = ST_SETUP;
            end
         end
         ST_SETUP: begin
            tmr_d = tmr_q + 4'd1;
            if (tmr_q == 4'(fssp_pkg::SETUP_CYC - 1)) begin
               tmr_d = 4'd0;
               st_d  = ST_PULSE;
            end
         end
         ST_PULSE: begin
            tmr_d = tmr_q + 4'd1;
            if (tmr_q == 4'(fssp_pkg::PULSE_CYC - 1)) begin
               tmr_d = 4'd0;
               if (rd_q || c_read) begin
                  rsp_d.data = rd_data;
               end
               st_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            tmr_d = tmr_q + 4'd1;
            if (tmr_q == 4'(fssp_pkg::HOLD_CYC - 1)) begin
               tmr_d = 4'd0;
               st_d  = ST_NEXT;
            end
         end
         ST_NEXT: begin
            if (rd_q) begin
               if (!first_q && rsp_q.data[fssp_pkg::ALT_BIT] == alt_q) begin
                  st_d = ST_DONE;
               end else if (!first_q && rsp_q.data[fssp_pkg::FAIL_BIT]) begin
                  // failure counts only while the toggle still moves
                  rsp_d.fail = 1'b1;
                  cur_d.op   = fssp_pkg::OP_ID_EXIT;
                  cyc_d      = 3'd0;
                  rd_d       = 1'b0;
                  st_d       = ST_SETUP;
               end else if (wt_q == 24'(POLL_LIMIT)) begin
                  rsp_d.timeout = 1'b1;
                  st_d          = ST_DONE;
               end else begin
                  st_d = ST_WAIT;
               end
               alt_d   = rsp_q.data[fssp_pkg::ALT_BIT];
               first_d = 1'b0;
               wt_d    = wt_q + 24'd1;
            end else if (cyc_q != n_cycles - 3'd1) begin
               cyc_d = cyc_q + 3'd1;
               st_d  = ST_SETUP;
            end else if (poll_after) begin
               wt_d    = 24'd0;
               first_d = 1'b1;
               st_d    = ST_WAIT;
            end else begin
               rsp_d.locked = rsp_q.data[fssp_pkg::LOCK_BIT];
               st_d         = ST_DONE;
               // leave identification mode after a half B status or lock report read; read word kept
               if (cur_q.op == fssp_pkg::OP_BLKB_STAT || cur_q.op == fssp_pkg::OP_LOCK_RPT) begin
                  cur_d.op = fssp_pkg::OP_ID_EXIT;
                  cyc_d    = 3'd0;
                  st_d     = ST_SETUP;
               end
            end
         end
         ST_WAIT: begin
            if (in_stable && (rdy_pin || !first_q)) begin
               rd_d = 1'b1;
               cur_d.op = fssp_pkg::OP_READ;
               st_d = ST_SETUP;
            end
         end
         ST_DONE: begin
            rsp_d.done = 1'b1;
            rd_d       = 1'b0;
            st_d       = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
      if (st_q == ST_IDLE && req_valid) begin
         rsp_d.fail    = 1'b0;
         rsp_d.timeout = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q    <= ST_IDLE;
         cur_q   <= '0;
         cyc_q   <= 3'd0;
         tmr_q   <= 4'd0;
         wt_q    <= 24'd0;
         rd_q    <= 1'b0;
         alt_q   <= 1'b0;
         first_q <= 1'b0;
         rsp_q   <= '0;
      end else begin
         st_q    <= st_d;
         cur_q   <= cur_d;
         cyc_q   <= cyc_d;
         tmr_q   <= tmr_d;
         wt_q    <= wt_d;
         rd_q    <= rd_d;
         alt_q   <= alt_d;
         first_q <= first_d;
         rsp_q   <= rsp_d;
      end
   end

   // Pin drive; strobes only in pulse phase, gate kept high on writes
   logic rd_cyc;
   always_comb begin
      rd_cyc = rd_q || c_read;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fl_addr  <= 20'h0_0000;
         fl_dq_o  <= 16'h0000;
         fl_dq_oe <= 1'b0;
         fl_ce_n  <= 1'b1;
         fl_oe_n  <= 1'b1;
         fl_we_n  <= 1'b1;
      end else begin
         fl_addr  <= rd_q ? cur_q.addr : c_addr;
         fl_dq_o  <= c_data;
         fl_dq_oe <= (st_d == ST_SETUP || st_d == ST_PULSE || st_d == ST_HOLD) && !rd_cyc;
         // Select spans the whole cycle so strobe edges never race it
         fl_ce_n  <= !(st_d == ST_SETUP || st_d == ST_PULSE || st_d == ST_HOLD);
         fl_oe_n  <= !(st_d == ST_PULSE && rd_cyc);
         // write strobe only with gate high
         fl_we_n  <= !(st_d == ST_PULSE && !rd_cyc);
      end
   end

   assign req_ready = (st_q == ST_IDLE);
   assign rsp       = rsp_q;
endmodule
`default_nettype wire

// *** fssp_pkg.sv ***
// Package for the parallel flash host controller: commands, addresses, timing.
// Assumes a 50 MHz system clock and an asynchronous flash on a 16-bit bus.
`default_nettype none
package fssp_pkg;
   localparam int unsigned CLK_MHZ       = 50;
   // Bus strobe phase lengths in cycles
   localparam int unsigned SETUP_CYC     = 3;
   localparam int unsigned PULSE_CYC     = 4;
   localparam int unsigned HOLD_CYC      = 3;
   // Suspend latencies in microseconds and cycles
   localparam int unsigned ERS_SUSP_US   = 15;
   localparam int unsigned PGM_SUSP_US   = 20;
   localparam int unsigned ERS_SUSP_CYC  = ERS_SUSP_US * CLK_MHZ;
   localparam int unsigned PGM_SUSP_CYC  = PGM_SUSP_US * CLK_MHZ;
   // Command addresses and codes
   localparam logic [11:0] ADDR_UNLK1    = 12'h555;
   localparam logic [11:0] ADDR_UNLK2    = 12'hAAA;
   localparam logic [11:0] ADDR_QUERY    = 12'h055;
   localparam logic [11:0] ADDR_LOCK_B   = 12'h080;
   localparam logic [11:0] ADDR_LOCK_RPT = 12'h002;
   localparam logic [7:0]  CODE_UNLK1    = 8'hAA;
   localparam logic [7:0]  CODE_UNLK2    = 8'h55;
   localparam logic [7:0]  CODE_SETUP    = 8'h80;
   localparam logic [7:0]  CODE_CHIP_ERS = 8'h10;
   localparam logic [7:0]  CODE_SECT_ERS = 8'h30;
   localparam logic [7:0]  CODE_LOCKDOWN = 8'h60;
   localparam logic [7:0]  CODE_PROGRAM  = 8'hA0;
   localparam logic [7:0]  CODE_SUSPEND  = 8'hB0;
   localparam logic [7:0]  CODE_RESUME   = 8'h30;
   localparam logic [7:0]  CODE_ID_ENTRY = 8'h90;
   localparam logic [7:0]  CODE_ID_EXIT  = 8'hF0;
   localparam logic [7:0]  CODE_SEC_REG  = 8'hC0;
   localparam logic [7:0]  CODE_SET_CFG  = 8'hD0;
   localparam logic [7:0]  CODE_QUERY    = 8'h98;
   localparam logic [7:0]  CODE_LOCK_B   = 8'hFD;
   // Status bit positions and config reset value
   localparam int unsigned POLL_BIT      = 7;
   localparam int unsigned ALT_BIT       = 6;
   localparam int unsigned FAIL_BIT      = 5;
   localparam int unsigned LOCK_BIT      = 0;
   localparam int unsigned BLKB_BIT      = 1;
   localparam logic [1:0]  CFG_RESET     = 2'h0;

   typedef enum logic [3:0] {
      OP_READ      = 4'h0,
      OP_PROGRAM   = 4'h1,
      OP_SECT_ERS  = 4'h2,
      OP_CHIP_ERS  = 4'h3,
      OP_LOCKDOWN  = 4'h4,
      OP_SUSPEND   = 4'h5,
      OP_RESUME    = 4'h6,
      OP_ID_EXIT   = 4'h7,
      OP_LOCK_RPT  = 4'h8,
      OP_SEC_PGM   = 4'h9,
      OP_LOCK_B    = 4'hA,
      OP_BLKB_STAT = 4'hB,
      OP_SET_CFG   = 4'hC,
      OP_QUERY     = 4'hD,
      OP_ID_ENTRY  = 4'hE
   } fssp_op_t;

   typedef struct packed {
      fssp_op_t    op;
      logic [19:0] addr;
      logic [15:0] data;
   } fssp_req_t;

   typedef struct packed {
      logic [15:0] data;
      logic        done;
      logic        fail;
      logic        timeout;
      logic        locked;
   } fssp_rsp_t;
endpackage
`default_nettype wire

// *** fssp_host_props.sv ***
// Checker for the flash host controller pins and request handling.
// Assumes a bind onto fssp_host; sees only its ports.
`default_nettype none
module fssp_host_props #(
   parameter int unsigned POLL_LIMIT = 100000
) (
   // Clock and reset
   input wire logic                clk,
   input wire logic                arst_n,
   // User side
   input wire fssp_pkg::fssp_req_t req,
   input wire logic                req_valid,
   input wire logic                req_ready,
   input wire fssp_pkg::fssp_rsp_t rsp,
   // Flash pins
   input wire logic [19:0]         fl_addr,
   input wire logic [15:0]         fl_dq_i,
   input wire logic [15:0]         fl_dq_o,
   input wire logic                fl_dq_oe,
   input wire logic                fl_ce_n,
   input wire logic                fl_oe_n,
   input wire logic                fl_we_n,
   input wire logic                fl_rdy_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   logic take;
   assign take = req_valid && req_ready;

   AST_WRITE_CLEAN: assert property (!fl_we_n |-> fl_oe_n && !fl_ce_n && fl_dq_oe)
      else $error("write strobe without clean select");
   AST_READ_CLEAN: assert property (!fl_oe_n |-> fl_we_n && !fl_ce_n && !fl_dq_oe)
      else $error("read gate with bus driven or strobe low");
   AST_WRITE_HELD: assert property (!fl_we_n && $past(!fl_we_n)
      |-> $stable({fl_addr, fl_dq_o})) else $error("address or data moved in a write");
   AST_QUERY_CYCLE: assert property (take && req.op == fssp_pkg::OP_QUERY
      |-> ##[1:16] (!fl_we_n && fl_addr[11:0] == fssp_pkg::ADDR_QUERY
      && fl_dq_o[7:0] == fssp_pkg::CODE_QUERY)) else $error("query write missing");
   AST_EXIT_CODE: assert property (take && req.op == fssp_pkg::OP_ID_EXIT
      |-> ##[1:48] (!fl_we_n && fl_dq_o[7:0] == fssp_pkg::CODE_ID_EXIT))
      else $error("exit code never written");
   AST_LOCK_B_BIT: assert property (take && req.op == fssp_pkg::OP_LOCK_B
      |-> ##[1:60] (!fl_we_n && fl_addr[11:0] == fssp_pkg::ADDR_LOCK_B
      && !fl_dq_o[fssp_pkg::BLKB_BIT])) else $error("lock cycle without bit one low");
   AST_UNLOCK_FIRST: assert property (take && req.op == fssp_pkg::OP_PROGRAM
      |-> ##[1:16] (!fl_we_n && fl_addr[11:0] == fssp_pkg::ADDR_UNLK1
      && fl_dq_o[7:0] == fssp_pkg::CODE_UNLK1)) else $error("unlock cycle missing");
   AST_SELECT_SPANS: assert property ($rose(fl_we_n) |-> !fl_ce_n)
      else $error("select released with write strobe");
   AST_DONE_PULSE: assert property (rsp.done |=> !rsp.done)
      else $error("done longer than one cycle");
   COV_QUERY: cover property (take && req.op == fssp_pkg::OP_QUERY);
   COV_FAIL: cover property (rsp.done && rsp.fail);
   COV_LOCK_B: cover property (take && req.op == fssp_pkg::OP_LOCK_B);
endmodule
`default_nettype wire

// *** fssp_flash_model.sv ***
// Behavioural flash seen from its pins; status, lockdown, suspend, half B.
// Assumes clk only paces internal work; sector is address bits 19:15.
`default_nettype none
module fssp_flash_model #(
   parameter int BUSY_CYC = 30
) (
   // Timing base and reset pin
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Bus pins
   input  wire logic [19:0] addr,
   input  wire logic [15:0] dq_wr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   output var  logic [15:0] dq_rd,
   output var  logic        rdy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [int];
   logic [31:0] lk = '0;
   logic [1:0]  cfg = 2'h0;
   logic        susp = 0, tog = 0, failm = 0, idm = 0, qm = 0, pgm = 0, blkb_lk = 0;
   logic [15:0] wdat = '0;
   int          seq = 0, pend = 0, busy = 0;
   initial dq_rd = 16'h5A5A;
   task automatic leave_modes();
      {failm, idm, qm} = 3'b000;
      seq = 0;
   endtask
   // Reset frees sectors, never touches cfg
   always @(negedge rst_n) begin
      lk = '0;
      busy = 0;
      susp = 1'b0;
      pend = 0;
      leave_modes();
   end
   // Only a clean write strobe counts
   always @(posedge we_n) if (!ce_n && oe_n && rst_n) begin
      if (pend == 1) begin
         if (lk[addr[19:15]]) failm = 1'b1;
         else mem[addr] = (mem.exists(addr) ? mem[addr] : 16'hFFFF) & dq_wr;
         {wdat, pgm, pend} = {dq_wr, 1'b1, 32'd0};
         busy = failm ? 0 : BUSY_CYC;
      end else if (pend == 2) begin
         // At address 080h only bit one decides the half B lock
         if (addr[11:0] == 12'h080 && !dq_wr[1]) blkb_lk = 1'b1;
         pend = 0;
      end else if (pend == 3) begin
         {cfg, pend} = {dq_wr[1:0], 32'd0};
      end else if (seq == 5) begin
         seq = 0;
         pgm = 1'b0;
         if (dq_wr[7:0] == 8'h60) lk[addr[19:15]] = 1'b1;
         // No fresh erase while one is suspended
         else if (!susp && dq_wr[7:0] == 8'h30) begin
            if (lk[addr[19:15]]) failm = 1'b1;
            else foreach (mem[k]) if (k[19:15] == addr[19:15]) mem[k] = 16'hFFFF;
            busy = failm ? 0 : BUSY_CYC;
         end else if (!susp && dq_wr[7:0] == 8'h10) begin
            foreach (mem[k]) if (!lk[k[19:15]]) mem[k] = 16'hFFFF;
            busy = BUSY_CYC;
         end
      end else if (dq_wr[7:0] == 8'hAA && addr[11:0] == 12'h555) seq = seq == 3 ? 4 : 1;
      else if (dq_wr[7:0] == 8'h55 && addr[11:0] == 12'hAAA && seq % 3 == 1) seq++;
      else if (seq == 2) begin
         seq = dq_wr[7:0] == 8'h80 ? 3 : 0;
         pend = dq_wr[7:0] == 8'hA0 ? 1 : dq_wr[7:0] == 8'hC0 ? 2 : dq_wr[7:0] == 8'hD0 ? 3 : 0;
         if (dq_wr[7:0] == 8'h90) idm = 1'b1;
         if (dq_wr[7:0] == 8'hF0) leave_modes();
      end
      else if (addr[11:0] == 12'h055 && dq_wr[7:0] == 8'h98) qm = 1'b1;
      // Shared suspend and resume codes, any address
      else if (dq_wr[7:0] == 8'hB0) susp = busy > 0;
      else if (dq_wr[7:0] == 8'h30) susp = 1'b0;
      else if (dq_wr[7:0] == 8'hF0) leave_modes();
      else seq = 0;
   end
   always @(posedge clk) if (busy > 0 && !susp) busy = busy - 1;
   // Each status read flips bit six
   always @(negedge oe_n) if (!ce_n && (failm || (busy > 0 && !susp))) tog = ~tog;
   function automatic logic [15:0] rd_word();
      logic poll;
      // Poll bit by cfg and operation
      poll = (cfg == 2'h0 && pgm) ? ~wdat[7] : 1'b0;
      // Status replaces array data while working
      if (failm || (busy > 0 && !susp)) return {8'h00, poll, tog, failm, 5'h00};
      // Lock report at sector offset two
      if (idm && addr[11:0] == 12'h002) return {15'h0000, lk[addr[19:15]]};
      // Half B lock shows as bit one low
      if (idm && addr[11:0] == 12'h080) return {14'h0000, !blkb_lk, 1'b0};
      if (qm) return 16'h0051;
      return mem.exists(addr) ? mem[addr] : 16'hFFFF;
   endfunction
   // Released bus keeps moving so a stale word never looks valid
   always @(ce_n, oe_n, addr, busy, susp, failm, tog, idm) begin
      if (!ce_n && !oe_n) dq_rd = rd_word();
      else dq_rd = ~dq_rd;
   end
   assign rdy = !(busy > 0 && !susp);
endmodule
`default_nettype wire

// *** test_fssp_host.sv ***
// Self-checking bench for the flash host controller against the flash model.
// Assumes a short poll limit; readback expectations come from a bench shadow array.
`default_nettype none
module test_fssp_host;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk = 1'b0;
   logic                arst_n = 1'b0;
   fssp_pkg::fssp_req_t req = '0;
   logic                req_valid = 1'b0;
   logic                req_ready, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rdy_i;
   fssp_pkg::fssp_rsp_t rsp, r;
   logic [19:0]         fl_addr, a;
   logic [15:0]         fl_dq_i, fl_dq_o, d;
   logic [15:0]         shadow [int];
   int                  fails = 0, samples_checked = 0, cycles = 0;

   fssp_host #(.POLL_LIMIT(20)) fssp_host_inst (.clk(clk), .arst_n(arst_n), .req(req),
      .req_valid(req_valid), .req_ready(req_ready), .rsp(rsp), .fl_addr(fl_addr),
      .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_rdy_i(fl_rdy_i));
   fssp_flash_model #(.BUSY_CYC(30)) fssp_flash_model_inst (.clk(clk), .rst_n(arst_n),
      .addr(fl_addr), .dq_wr(fl_dq_o), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n),
      .dq_rd(fl_dq_i), .rdy(fl_rdy_i));

   always #10 clk = ~clk;
   task automatic stop_test();
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] exp_rd(input logic [19:0] ad);
      return shadow.exists(ad) ? shadow[ad] : 16'hFFFF;
   endfunction
   // One request held until taken, then bounded wait for done
   task automatic run(input fssp_pkg::fssp_op_t op, input logic [19:0] ad, input logic [15:0] dt);
      int n;
      n = 0;
      @(negedge clk);
      req = '{op: op, addr: ad, data: dt};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      while (rsp.done !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      r = rsp;
      check("done seen", 16'(n < 3000), 16'h0001);
   endtask

   initial begin
      void'($urandom(38));
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      for (int i = 0; i < 10; i++) begin
         a = i == 0 ? 20'h08004 : {5'($urandom_range(3, 1)), 15'($urandom)};
         d = i == 0 ? 16'h0080 : i == 1 ? 16'h0000 : 16'($urandom);
         if (i == 5) run(fssp_pkg::OP_SET_CFG, 20'h00000, 16'h0001);
         run(fssp_pkg::OP_PROGRAM, a, d);
         shadow[a] = exp_rd(a) & d;
         check("program flags", {14'h0000, r.fail, r.timeout}, 16'h0000);
         run(fssp_pkg::OP_READ, a, 16'h0000);
         check("readback", r.data, exp_rd(a));
      end
      run(fssp_pkg::OP_SECT_ERS, 20'h08100, 16'h0000);
      run(fssp_pkg::OP_READ, 20'h08004, 16'h0000);
      check("erased word", r.data, 16'hFFFF);
      run(fssp_pkg::OP_LOCKDOWN, 20'h00100, 16'h0000);
      for (int s = 0; s < 2; s++) begin
         run(fssp_pkg::OP_LOCK_RPT, {5'(s), 15'h0000}, 16'h0000);
         check("lock report", {15'h0000, r.data[0]}, 16'(s == 0));
         check("lock flag", {15'h0000, r.locked}, 16'(s == 0));
         run(fssp_pkg::OP_ID_EXIT, 20'h00000, 16'h0000);
      end
      run(fssp_pkg::OP_PROGRAM, 20'h00010, 16'h1234);
      check("locked program fail", {15'h0000, r.fail}, 16'h0001);
      run(fssp_pkg::OP_ID_EXIT, 20'h00000, 16'h0000);
      run(fssp_pkg::OP_READ, 20'h00010, 16'h0000);
      check("locked word", r.data, 16'hFFFF);
      run(fssp_pkg::OP_SUSPEND, 20'h12345, 16'h0000);
      run(fssp_pkg::OP_RESUME, 20'h00000, 16'h0000);
      run(fssp_pkg::OP_QUERY, 20'h00000, 16'h0000);
      run(fssp_pkg::OP_ID_EXIT, 20'h00000, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         run(fssp_pkg::OP_BLKB_STAT, 20'h00000, 16'h0000);
         check("half b state", {15'h0000, r.data[1]}, 16'(k == 0));
         run(fssp_pkg::OP_ID_EXIT, 20'h00000, 16'h0000);
         if (k == 0) run(fssp_pkg::OP_LOCK_B, 20'h00080, 16'h00FD);
      end
      // Second reset mid-run must free the sector again
      @(negedge clk);
      arst_n = 1'b0;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      run(fssp_pkg::OP_PROGRAM, 20'h00010, 16'h00FF);
      check("freed program", {15'h0000, r.fail}, 16'h0000);
      run(fssp_pkg::OP_LOCKDOWN, 20'h00000, 16'h0000);
      run(fssp_pkg::OP_CHIP_ERS, 20'h00000, 16'h0000);
      run(fssp_pkg::OP_READ, 20'h00010, 16'h0000);
      check("kept after chip erase", r.data, 16'h00FF);
      stop_test();
   end
endmodule
bind fssp_host fssp_host_props #(.POLL_LIMIT(POLL_LIMIT)) fssp_host_props_inst (.clk(clk),
   .arst_n(arst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp(rsp),
   .fl_addr(fl_addr), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
   .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_rdy_i(fl_rdy_i));
`default_nettype wire
